//--- design/gap_write_pkg.sv
// constants, field layout and types of the gap write decoder
// assumes a 10 MHz system clock and a field clock sampled as a plain input
package gap_write_pkg;

    // system clock and programming time
    localparam int CLK_MHZ = 10;
    localparam int PROG_TIME_MS = 16;
    localparam int PROG_CYCLES_DFLT = PROG_TIME_MS * 1000 * CLK_MHZ;

    // interval classification, in field clocks
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] ZERO_MIN = 7'h10;
    localparam logic [CNT_W-1:0] ZERO_MAX = 7'h20;
    localparam logic [CNT_W-1:0] ONE_MIN = 7'h30;
    localparam logic [CNT_W-1:0] ONE_MAX = 7'h40;
    localparam logic [CNT_W-1:0] CNT_SAT = 7'h7F;
    localparam logic [CNT_W-1:0] CNT_STEP = 7'h01;

    // frame layout: opcode, lock, data, address, first bit is the msb
    localparam int BITS_W = 6;
    localparam logic [BITS_W-1:0] OP_LAST = 6'h01;
    localparam logic [BITS_W-1:0] OP_BITS = 6'h02;
    localparam logic [BITS_W-1:0] FRAME_BITS = 6'h26;
    localparam logic [BITS_W-1:0] BITS_STEP = 6'h01;
    localparam logic [1:0] WRITE_OPCODE = 2'h2;
    localparam int FRAME_W = 38;
    localparam int CMD_W = 36;
    localparam int DATA_BITS = 32;
    localparam int ADDR_W = 3;
    localparam int CMD_DATA_LSB = 3;
    localparam int CMD_LOCK_POS = 35;

    // memory: 8 blocks of 33 bits, lock bit on top
    localparam int BLOCKS = 8;
    localparam int BLOCK_W = 33;
    localparam int LOCK_POS = 32;
    localparam logic [BITS_W-1:0] BLOCK_LAST_BIT = 6'h20;
    localparam logic [ADDR_W-1:0] BLK_STEP = 3'h1;

    // read mode: one bit every 32 field clocks
    localparam logic [4:0] READ_RATE_LAST = 5'h1F;
    localparam logic [4:0] RATE_STEP = 5'h01;

    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        ST_READ = 2'b00,
        ST_WRITE = 2'b01
    } mode_type;

endpackage

//--- design/gap_write_decoder.sv
// gap write decoder: decodes field-gap writes, queues block writes, programs memory
// assumes gap_i and field_clk_i are asynchronous levels from the analog front end
`timescale 1ns/1ps

module cmd_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } fifo_state_type;

    fifo_state_type s_reg;
    fifo_state_type s_next;
    logic full;
    logic empty;

    assign full = (s_reg.wp[AW] != s_reg.rp[AW]) && (s_reg.wp[AW-1:0] == s_reg.rp[AW-1:0]);
    assign empty = (s_reg.wp == s_reg.rp);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = s_reg.mem[s_reg.rp[AW-1:0]];

    always_comb begin
        s_next = s_reg;
        if (in_valid_i && !full) begin
            s_next.mem[s_reg.wp[AW-1:0]] = in_data_i;
            s_next.wp = (AW+1)'(s_reg.wp + 1);
        end
        if (out_ready_i && !empty) begin
            s_next.rp = (AW+1)'(s_reg.rp + 1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

module gap_write_decoder #(
    parameter int PROG_CYCLES = gap_write_pkg::PROG_CYCLES_DFLT
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // analog front end
    input wire logic gap_i,
    input wire logic field_clk_i,
    // coil load modulation
    output logic load_mod_o,
    // status
    output logic write_mode_o,
    output logic decode_err_o,
    output logic frame_ok_o,
    output logic prog_busy_o,
    output logic prog_done_o,
    output logic prog_locked_o
);
    typedef struct packed {
        gap_write_pkg::mode_type st;
        logic gap_s1;
        logic gap_s2;
        logic gap_s3;
        logic fclk_s1;
        logic fclk_s2;
        logic fclk_s3;
        logic [gap_write_pkg::CNT_W-1:0] cnt;
        logic [gap_write_pkg::BITS_W-1:0] bits;
        logic [gap_write_pkg::FRAME_W-1:0] frame;
        logic busy;
        logic [31:0] pcnt;
        logic [gap_write_pkg::CMD_W-1:0] wcmd;
        logic [gap_write_pkg::BLOCKS-1:0][gap_write_pkg::BLOCK_W-1:0] mem;
        logic [4:0] rate;
        logic [gap_write_pkg::BITS_W-1:0] rbit;
        logic [gap_write_pkg::ADDR_W-1:0] rblk;
        logic mod;
        logic wmode;
        logic err;
        logic ok;
        logic done;
        logic locked;
    } dec_state_type;

    localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

    dec_state_type s_reg;
    dec_state_type s_next;
    logic gap_edge;
    logic fclk_rise;
    logic is_zero;
    logic is_one;
    logic push_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [gap_write_pkg::CMD_W-1:0] fifo_out;
    logic [gap_write_pkg::ADDR_W-1:0] waddr;

    assign gap_edge = s_reg.gap_s2 && !s_reg.gap_s3;
    assign fclk_rise = s_reg.fclk_s2 && !s_reg.fclk_s3;
    assign is_zero = (s_reg.cnt >= gap_write_pkg::ZERO_MIN) && (s_reg.cnt <= gap_write_pkg::ZERO_MAX);
    assign is_one = (s_reg.cnt >= gap_write_pkg::ONE_MIN) && (s_reg.cnt <= gap_write_pkg::ONE_MAX);
    assign waddr = s_reg.wcmd[gap_write_pkg::ADDR_W-1:0];

    cmd_fifo #(
        .WIDTH(gap_write_pkg::CMD_W),
        .DEPTH(gap_write_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(s_reg.frame[gap_write_pkg::CMD_W-1:0]),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(!s_reg.busy),
        .out_data_o(fifo_out)
    );

    always_comb begin
        s_next = s_reg;
        push_valid = 1'b0;
        s_next.err = 1'b0;
        s_next.ok = 1'b0;
        s_next.done = 1'b0;
        s_next.locked = 1'b0;
        s_next.gap_s1 = gap_i;
        s_next.gap_s2 = s_reg.gap_s1;
        s_next.gap_s3 = s_reg.gap_s2;
        s_next.fclk_s1 = field_clk_i;
        s_next.fclk_s2 = s_reg.fclk_s1;
        s_next.fclk_s3 = s_reg.fclk_s2;
        // interval counter restarted by every gap
        if (gap_edge) begin
            s_next.cnt = '0;
        end else if (fclk_rise && s_reg.cnt != gap_write_pkg::CNT_SAT) begin
            s_next.cnt = s_reg.cnt + gap_write_pkg::CNT_STEP;
        end
        case (s_reg.st)
            gap_write_pkg::ST_READ: begin
                if (gap_edge) begin
                    s_next.st = gap_write_pkg::ST_WRITE;
                    s_next.bits = '0;
                end
            end
            gap_write_pkg::ST_WRITE: begin
                if (gap_edge) begin
                    // bad interval, wrong opcode or an extra bit drops the frame
                    if ((!is_zero && !is_one) || s_reg.bits == gap_write_pkg::FRAME_BITS ||
                        (s_reg.bits == gap_write_pkg::OP_LAST &&
                         {s_reg.frame[0], is_one} != gap_write_pkg::WRITE_OPCODE)) begin
                        s_next.st = gap_write_pkg::ST_READ;
                        s_next.err = 1'b1;
                    end else begin
                        s_next.frame = {s_reg.frame[gap_write_pkg::FRAME_W-2:0], is_one};
                        s_next.bits = s_reg.bits + gap_write_pkg::BITS_STEP;
                    end
                end else if (s_reg.cnt > gap_write_pkg::ONE_MAX) begin
                    // no further gap: the frame has ended
                    s_next.st = gap_write_pkg::ST_READ;
                    if (s_reg.bits == gap_write_pkg::FRAME_BITS) begin
                        push_valid = 1'b1;
                        s_next.ok = fifo_in_ready;
                        s_next.err = !fifo_in_ready;
                    end else begin
                        s_next.err = 1'b1;
                    end
                end
            end
            default: begin
                s_next.st = gap_write_pkg::ST_READ;
            end
        endcase
        // block programming, one queued command at a time
        if (!s_reg.busy) begin
            if (fifo_out_valid) begin
                s_next.busy = 1'b1;
                s_next.wcmd = fifo_out;
                s_next.pcnt = '0;
            end
        end else if (s_reg.pcnt == PROG_LAST) begin
            s_next.busy = 1'b0;
            if (s_reg.mem[waddr][gap_write_pkg::LOCK_POS]) begin
                s_next.locked = 1'b1;
            end else begin
                s_next.mem[waddr] = {s_reg.wcmd[gap_write_pkg::CMD_LOCK_POS],
                    s_reg.wcmd[gap_write_pkg::CMD_DATA_LSB +: gap_write_pkg::DATA_BITS]};
                s_next.done = 1'b1;
            end
        end else begin
            s_next.pcnt = s_reg.pcnt + 32'h00000001;
        end
        // read mode: stream blocks bit by bit onto the coil load
        if (s_reg.st == gap_write_pkg::ST_READ && fclk_rise) begin
            if (s_reg.rate == gap_write_pkg::READ_RATE_LAST) begin
                s_next.rate = '0;
                if (s_reg.rbit == gap_write_pkg::BLOCK_LAST_BIT) begin
                    s_next.rbit = '0;
                    s_next.rblk = s_reg.rblk + gap_write_pkg::BLK_STEP;
                end else begin
                    s_next.rbit = s_reg.rbit + gap_write_pkg::BITS_STEP;
                end
            end else begin
                s_next.rate = s_reg.rate + gap_write_pkg::RATE_STEP;
            end
        end
        // load released in the same cycle in which write mode starts
        s_next.mod = (s_next.st == gap_write_pkg::ST_READ) && s_reg.mem[s_reg.rblk][s_reg.rbit];
        s_next.wmode = (s_next.st == gap_write_pkg::ST_WRITE);
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign load_mod_o = s_reg.mod;
    assign write_mode_o = s_reg.wmode;
    assign decode_err_o = s_reg.err;
    assign frame_ok_o = s_reg.ok;
    assign prog_busy_o = s_reg.busy;
    assign prog_done_o = s_reg.done;
    assign prog_locked_o = s_reg.locked;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_gap_in_write;
        s_reg.st == gap_write_pkg::ST_WRITE && gap_edge;
    endsequence

    sequence s_zero_gap;
        s_gap_in_write ##0 (s_reg.cnt >= gap_write_pkg::ZERO_MIN && s_reg.cnt <= gap_write_pkg::ZERO_MAX);
    endsequence

    sequence s_one_gap;
        s_gap_in_write ##0 (s_reg.cnt >= gap_write_pkg::ONE_MIN && s_reg.cnt <= gap_write_pkg::ONE_MAX);
    endsequence

    a_zero_decode: assert property (s_zero_gap |=>
        (s_reg.frame[0] == 1'b0 || s_reg.st == gap_write_pkg::ST_READ))
        else $error("zero interval not decoded as zero");
    a_one_decode: assert property (s_one_gap |=>
        (s_reg.frame[0] == 1'b1 || s_reg.st == gap_write_pkg::ST_READ))
        else $error("one interval not decoded as one");
    a_bad_abort: assert property (s_gap_in_write ##0
        (!(s_reg.cnt >= gap_write_pkg::ZERO_MIN && s_reg.cnt <= gap_write_pkg::ZERO_MAX) &&
        !(s_reg.cnt >= gap_write_pkg::ONE_MIN && s_reg.cnt <= gap_write_pkg::ONE_MAX))
        |=> s_reg.st == gap_write_pkg::ST_READ && decode_err_o)
        else $error("invalid interval did not abort");
    a_cnt_clear: assert property (gap_edge |=> s_reg.cnt == '0)
        else $error("counter not cleared on gap");
    a_cnt_sat: assert property (s_reg.cnt == gap_write_pkg::CNT_SAT && !gap_edge |=>
        s_reg.cnt == gap_write_pkg::CNT_SAT)
        else $error("counter wrapped");
    a_opcode_ok: assert property (s_reg.st == gap_write_pkg::ST_WRITE &&
        s_reg.bits == gap_write_pkg::OP_BITS |-> s_reg.frame[1:0] == gap_write_pkg::WRITE_OPCODE)
        else $error("frame kept with wrong opcode");
    a_push_exact: assert property (push_valid |-> $past(s_reg.bits) == gap_write_pkg::FRAME_BITS &&
        s_reg.bits == gap_write_pkg::FRAME_BITS)
        else $error("push with wrong bit count");
    a_frame_end: assert property (s_reg.st == gap_write_pkg::ST_WRITE && !gap_edge &&
        s_reg.cnt > gap_write_pkg::ONE_MAX |=> !write_mode_o && (frame_ok_o || decode_err_o))
        else $error("frame end not reported");
    a_lock_keep: assert property (s_reg.busy && s_reg.pcnt == PROG_LAST &&
        s_reg.mem[waddr][gap_write_pkg::LOCK_POS] |=> s_reg.mem == $past(s_reg.mem) && prog_locked_o && !prog_done_o)
        else $error("locked block overwritten");
    a_mod_quiet: assert property (s_reg.st == gap_write_pkg::ST_WRITE |-> !load_mod_o)
        else $error("load modulated in write mode");
endmodule

//--- verification/base_station_model.sv
// base station model: free-running carrier clock and field gaps that carry write frames
// assumes the carrier runs without pause and each bit is timed in carrier clocks between gaps
`timescale 1ns/1ps

module base_station_model (
    // field
    output logic field_clk_o,
    output logic gap_o
);
    initial begin
        field_clk_o = 1'b0;
        gap_o = 1'b0;
        forever #400 field_clk_o = ~field_clk_o;
    end

    // gap rises n carrier rises after the previous gap
    task automatic gap_after(input int n);
        repeat (n) @(posedge field_clk_o);
        @(negedge field_clk_o);
        gap_o = 1'b1;
        #300 gap_o = 1'b0;
    endtask

    // wide picks the upper bound of each window on odd positions, the lower one elsewhere
    task automatic send_frame(input logic [37:0] f, input int n_bits, input bit wide);
        int i;
        gap_after(4);
        for (i = 37; i > 37 - n_bits; i--) begin
            gap_after(f[i] ? ((wide && i[0]) ? 64 : 48) : ((wide && i[0]) ? 32 : 16));
        end
    endtask
endmodule

//--- verification/gap_write_decoder_tb.sv
// testbench of the gap write decoder: frames, bad intervals, framing faults, lock protection
// assumes a 10 MHz clock and the base station model driving the field inputs
`timescale 1ns/1ps

module gap_write_decoder_tb;
    localparam int PROG_N = 20;
    logic clk_i;
    logic rstn_i;
    logic field_clk;
    logic gap;
    logic load_mod_o, write_mode_o, decode_err_o, frame_ok_o;
    logic prog_busy_o, prog_done_o, prog_locked_o;
    int mismatches = 0;
    int cmp_count = 0;
    logic [15:0] ok_n, err_n, done_n, lock_n, busy_n, load_wr_n;
    logic cnt_clr;

    base_station_model bs (.field_clk_o(field_clk), .gap_o(gap));

    gap_write_decoder #(.PROG_CYCLES(PROG_N)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .gap_i(gap), .field_clk_i(field_clk),
        .load_mod_o(load_mod_o), .write_mode_o(write_mode_o), .decode_err_o(decode_err_o),
        .frame_ok_o(frame_ok_o), .prog_busy_o(prog_busy_o), .prog_done_o(prog_done_o),
        .prog_locked_o(prog_locked_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // event counters of the output pulses and levels
    always @(posedge clk_i) begin
        if (cnt_clr) begin
            {ok_n, err_n, done_n, lock_n, busy_n, load_wr_n} <= '0;
        end else begin
            ok_n <= ok_n + 16'(frame_ok_o === 1'b1);
            err_n <= err_n + 16'(decode_err_o === 1'b1);
            done_n <= done_n + 16'(prog_done_o === 1'b1);
            lock_n <= lock_n + 16'(prog_locked_o === 1'b1);
            busy_n <= busy_n + 16'(prog_busy_o === 1'b1);
            load_wr_n <= load_wr_n + 16'(write_mode_o !== 1'b0 && load_mod_o !== 1'b0);
        end
    end

    task automatic clear_counts();
        @(negedge clk_i);
        cnt_clr = 1'b1;
        @(negedge clk_i);
        cnt_clr = 1'b0;
    endtask

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic settle();
        repeat (80) @(posedge field_clk);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic test_good_frame();
        clear_counts();
        bs.send_frame({2'b10, 1'b0, 32'hA5C3_0F97, 3'h0}, 38, 1'b1);
        settle();
        check_val("frame_ok", 16'h0001, ok_n);
        check_val("decode_err", 16'h0000, err_n);
        check_val("prog_done", 16'h0001, done_n);
        check_val("busy_cycles", 16'(PROG_N), busy_n);
        check_val("load_in_write", 16'h0000, load_wr_n);
        check_val("write_mode", 16'h0000, 16'(write_mode_o));
        // read pointer has spent well under 32 field clocks in read mode: still on block 0 bit 0
        check_val("load_block0_bit0", 16'h0001, 16'(load_mod_o));
        $display("test good_frame done");
    endtask

    task automatic test_lock();
        clear_counts();
        bs.send_frame({2'b10, 1'b1, 32'h1234_5678, 3'h5}, 38, 1'b0);
        settle();
        check_val("locking_write_done", 16'h0001, done_n);
        bs.send_frame({2'b10, 1'b0, 32'hFFFF_0000, 3'h5}, 38, 1'b0);
        settle();
        check_val("frames_queued", 16'h0002, ok_n);
        check_val("refused_locked", 16'h0001, lock_n);
        check_val("done_total", 16'h0001, done_n);
        bs.send_frame({2'b10, 1'b0, 32'h0000_0001, 3'h6}, 38, 1'b0);
        settle();
        check_val("other_block_done", 16'h0002, done_n);
        $display("test lock done");
    endtask

    task automatic test_bad_intervals();
        int bad[4] = '{15, 33, 47, 65};
        int k;
        for (k = 0; k < 4; k++) begin
            clear_counts();
            bs.gap_after(4);
            bs.gap_after(48);
            check_val("write_mode_on", 16'h0001, 16'(write_mode_o));
            bs.gap_after(bad[k]);
            repeat (20) @(posedge clk_i);
            check_val("bad_interval_err", 16'h0001, err_n);
            settle();
            check_val("bad_interval_ok", 16'h0000, ok_n);
        end
        $display("test bad_intervals done");
    endtask

    task automatic test_opcode();
        int k;
        for (k = 0; k < 2; k++) begin
            clear_counts();
            bs.gap_after(4);
            bs.gap_after(k == 0 ? 16 : 48);
            bs.gap_after(48);
            repeat (20) @(posedge clk_i);
            check_val("opcode_err", 16'h0001, err_n);
            settle();
            check_val("opcode_no_write", 16'h0000, ok_n);
        end
        $display("test opcode done");
    endtask

    task automatic test_bit_count();
        clear_counts();
        bs.send_frame({2'b10, 1'b0, 32'h0000_FFFF, 3'h1}, 37, 1'b0);
        settle();
        check_val("short_err", 16'h0001, err_n);
        check_val("short_ok", 16'h0000, ok_n);
        clear_counts();
        bs.send_frame({2'b10, 1'b0, 32'h0000_FFFF, 3'h1}, 38, 1'b0);
        bs.gap_after(16);
        repeat (20) @(posedge clk_i);
        check_val("long_err", 16'h0001, err_n);
        settle();
        check_val("long_done", 16'h0000, done_n);
        $display("test bit_count done");
    endtask

    initial begin
        rstn_i = 1'b0;
        cnt_clr = 1'b1;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (5) @(posedge clk_i);
        test_good_frame();
        test_lock();
        test_bad_intervals();
        test_opcode();
        test_bit_count();
        finish_test();
    end

    // cuts a hang short: the tests take about 7 ms
    initial begin
        #9_000_000;
        mismatches++;
        finish_test();
    end
endmodule
